//--- sct_pkg.sv
// Package for the sample clock trim and sync block.
// Holds register addresses, field positions, reset values and timing.
// Assumes a word-wide register port with 8-bit addresses.
package sct_pkg;
	// Register addresses.
	localparam logic [7:0] SCT_ADDR_RATIO = 8'h0A;
	localparam logic [7:0] SCT_ADDR_RATE = 8'h12;
	localparam logic [7:0] SCT_ADDR_SLOW = 8'h4B;
	localparam logic [7:0] SCT_ADDR_FAST = 8'h4D;
	localparam logic [7:0] SCT_ADDR_TIMING = 8'h4E;
	localparam logic [7:0] SCT_ADDR_SYNC = 8'h4F;
	localparam logic [7:0] SCT_ADDR_CAL = 8'h50;
	localparam logic [7:0] SCT_ADDR_OSYNC = 8'h38;
	// Reset values of whole registers.
	localparam logic [15:0] SCT_RST_SLOW = 16'h2612;
	localparam logic [15:0] SCT_RST_FAST = 16'h425E;
	localparam logic [15:0] SCT_RST_TIMING = 16'h0060;
	localparam logic [15:0] SCT_RST_SYNC = 16'h0000;
	localparam logic [15:0] SCT_RST_CAL = 16'h0000;
	localparam logic [15:0] SCT_RST_OSYNC = 16'h0000;
	localparam logic [15:0] SCT_RST_RATE = 16'h0028;
	// Field positions.
	localparam int SCT_BIT_SLOW_EN = 7;
	localparam int SCT_BIT_SYNC_SRC = 2;
	localparam int SCT_BIT_IRQ_IE = 1;
	localparam int SCT_BIT_CAL_START = 5;
	localparam int SCT_BIT_OSYNC = 14;
	// Trim codes: one end and the centre of the slow range, and the fast default.
	localparam logic [5:0] SCT_SLOW_TRIM_MAX_F = 6'h00;
	localparam logic [5:0] SCT_SLOW_TRIM_MID = 6'h22;
	localparam logic [7:0] SCT_FAST_TRIM_DEF = 8'h5E;
	// Sample rate divider multiplier.
	localparam int SCT_RATE_MULT = 4;
	// Length of a ratio measurement, in slow clock ticks.
	localparam int SCT_CAL_TICKS = 8;
endpackage : sct_pkg

//--- sct_tick_div.sv
// Programmable tick divider for the sample clock trim and sync block.
// Assumes one clock; emits one-cycle enable pulses, never a derived clock.
`timescale 1ns/1ns
module sct_tick_div #(
	parameter int WIDTH = 18
) (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Control.
	input wire logic run_in,
	input wire logic [WIDTH-1:0] period_in,
	// Output pulse.
	output logic tick_out
);
	// Counter state.
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_tick;

	// Count down to one, then reload; halted counters restart from period.
	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (!run_in) begin
			next_count = period_in;
		end else if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
			next_count = period_in;
			next_tick = 1'b1;
		end else begin
			next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Register the state.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count <= '0;
			tick_out <= 1'b0;
		end else begin
			count <= next_count;
			tick_out <= next_tick;
		end
	end
endmodule : sct_tick_div

//--- sct_clock_ctrl.sv
// Sample clock trim and sync control: registers, trim outputs, sample
// timing source selection and fast to slow clock ratio measurement.
// Assumes a host register port (address, write strobe, read strobe)
// already decoded from the two-wire interface, and that the fast oscillator
// reports its edges as an asynchronous level on a pin.
`timescale 1ns/1ns
module sct_clock_ctrl #(
	parameter int RATE_W = 16,
	parameter int SLOW_DIV = 312
) (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Register port.
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	// Interrupt pin, input side.
	input wire logic irq_pin_in,
	// Fast oscillator edge, as seen from outside.
	input wire logic fast_osc_in,
	// Trim and status outputs.
	output logic [5:0] slow_clock_trim_out,
	output logic [7:0] fast_clock_trim_out,
	output logic slow_clock_enable_out,
	output logic sample_start_out,
	output logic ratio_busy_out
);
	import sct_pkg::*;

	// Every check below lives on the one reference clock and is quiet in
	// reset, so the clock and the disable are declared once, up here.
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);

	// Register storage.
	logic [15:0] slow_clock_control, next_slow;
	logic [15:0] fast_clock_trim_control, next_fast;
	logic [15:0] converter_timing_setting, next_timing;
	logic [15:0] sample_sync_config, next_sync;
	logic [15:0] clock_calibration_control, next_cal;
	logic [15:0] outside_sync_reg, next_osync;
	logic [RATE_W-1:0] sample_rate_divider, next_rate;
	logic [15:0] next_rdata;

	// Field views.
	wire slow_clock_enable = slow_clock_control[SCT_BIT_SLOW_EN];
	wire sample_sync_source = sample_sync_config[SCT_BIT_SYNC_SRC];
	wire irq_pin_input_enable = sample_sync_config[SCT_BIT_IRQ_IE];
	wire fast_clock_ratio_start = clock_calibration_control[SCT_BIT_CAL_START];

	// Ratio measurement state, one-hot.
	typedef enum logic [1:0] {
		SCT_IDLE = 2'b01,
		SCT_MEAS = 2'b10
	} sct_cal_t;
	sct_cal_t cal_state, next_cal_state;
	logic [15:0] clk_ratio, next_ratio; // Fast edges per window.
	logic [15:0] fast_cnt, next_fast_cnt;
	logic [7:0] win_cnt, next_win_cnt;
	logic start_seen, next_start_seen; // Start level seen by the engine.

	// Pin synchronisers: stage one feeds only stage two.
	logic [2:0] irq_sync;
	logic [2:0] fast_sync;
	logic irq_level, next_irq_level;
	logic fast_level, next_fast_level;

	// Slow clock tick: the internal slow oscillator is modelled as an
	// enable derived from the reference clock, gated by its power bit.
	logic slow_tick;
	sct_tick_div #(.WIDTH(16)) u_slow (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.run_in(slow_clock_enable),
		.period_in(16'(SLOW_DIV)),
		.tick_out(slow_tick)
	);

	// Sample period counter in slow ticks: divider times four.
	logic [RATE_W+1:0] samp_cnt, next_samp_cnt;
	logic next_sample;
	wire [RATE_W+1:0] samp_period = {sample_rate_divider, 2'b00};

	// Register writes; the start bit is held as written, and the engine
	// acts only on its rising level, so software must drop it first.
	always_comb begin
		next_slow = slow_clock_control;
		next_fast = fast_clock_trim_control;
		next_timing = converter_timing_setting;
		next_sync = sample_sync_config;
		next_cal = clock_calibration_control;
		next_osync = outside_sync_reg;
		next_rate = sample_rate_divider;
		if (reg_wr_in) begin
			case (reg_addr_in)
				SCT_ADDR_SLOW: next_slow = reg_wdata_in;
				SCT_ADDR_FAST: next_fast = reg_wdata_in;
				SCT_ADDR_TIMING: next_timing = reg_wdata_in;
				SCT_ADDR_SYNC: next_sync = reg_wdata_in;
				SCT_ADDR_CAL: next_cal = reg_wdata_in;
				SCT_ADDR_OSYNC: next_osync = reg_wdata_in;
				SCT_ADDR_RATE: next_rate = reg_wdata_in[RATE_W-1:0];
				default: ; // Unmapped writes are dropped.
			endcase
		end
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		next_rdata = reg_rdata_out;
		if (reg_rd_in) begin
			case (reg_addr_in)
				SCT_ADDR_SLOW: next_rdata = slow_clock_control;
				SCT_ADDR_FAST: next_rdata = fast_clock_trim_control;
				SCT_ADDR_TIMING: next_rdata = converter_timing_setting;
				SCT_ADDR_SYNC: next_rdata = sample_sync_config;
				SCT_ADDR_CAL: next_rdata = clock_calibration_control;
				SCT_ADDR_OSYNC: next_rdata = outside_sync_reg;
				SCT_ADDR_RATE: next_rdata = 16'(sample_rate_divider);
				SCT_ADDR_RATIO: next_rdata = clk_ratio;
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	// Sample timing source: internal count or gated pin edge.
	always_comb begin
		next_irq_level = irq_level;
		next_fast_level = fast_level;
		// A change counts once the second and third stages agree.
		if (irq_sync[1] == irq_sync[2]) next_irq_level = irq_sync[2];
		if (fast_sync[1] == fast_sync[2]) next_fast_level = fast_sync[2];
		next_samp_cnt = samp_cnt;
		next_sample = 1'b0;
		if (!slow_clock_enable) begin
			next_samp_cnt = '0; // Clock off, no samples.
		end else if (!sample_sync_source) begin
			if (slow_tick) begin
				if (samp_cnt + 1'b1 >= samp_period) begin
					next_samp_cnt = '0;
					next_sample = (samp_period != '0);
				end else begin
					next_samp_cnt = samp_cnt + 1'b1;
				end
			end
		end else begin
			next_samp_cnt = '0;
			// Rising pin edge, only while the input is enabled.
			next_sample = irq_pin_input_enable && next_irq_level &&
				!irq_level;
		end
	end

	// Ratio engine: count fast edges over a window of slow ticks.
	always_comb begin
		next_cal_state = cal_state;
		next_ratio = clk_ratio;
		next_fast_cnt = fast_cnt;
		next_win_cnt = win_cnt;
		next_start_seen = fast_clock_ratio_start;
		case (cal_state)
			SCT_IDLE: begin
				// Relaunch only after the bit went back to zero.
				if (fast_clock_ratio_start && !start_seen) begin
					next_cal_state = SCT_MEAS;
					next_fast_cnt = '0;
					next_win_cnt = '0;
				end
			end
			SCT_MEAS: begin
				if (next_fast_level && !fast_level) begin
					next_fast_cnt = fast_cnt + 16'h0001;
				end
				if (slow_tick) begin
					next_win_cnt = win_cnt + 8'h01;
					if (win_cnt + 8'h01 == 8'(SCT_CAL_TICKS)) begin
						next_ratio = fast_cnt;
						next_cal_state = SCT_IDLE;
					end
				end
			end
			default: next_cal_state = SCT_IDLE;
		endcase
	end

	// Register all state.
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			slow_clock_control <= SCT_RST_SLOW;
			fast_clock_trim_control <= SCT_RST_FAST;
			converter_timing_setting <= SCT_RST_TIMING;
			sample_sync_config <= SCT_RST_SYNC;
			clock_calibration_control <= SCT_RST_CAL;
			outside_sync_reg <= SCT_RST_OSYNC;
			sample_rate_divider <= RATE_W'(SCT_RST_RATE);
			reg_rdata_out <= 16'h0000;
			irq_sync <= 3'b000;
			fast_sync <= 3'b000;
			irq_level <= 1'b0;
			fast_level <= 1'b0;
			samp_cnt <= '0;
			sample_start_out <= 1'b0;
			cal_state <= SCT_IDLE;
			clk_ratio <= 16'h0000;
			fast_cnt <= 16'h0000;
			win_cnt <= 8'h00;
			start_seen <= 1'b0;
			slow_clock_trim_out <= SCT_RST_SLOW[5:0];
			fast_clock_trim_out <= SCT_RST_FAST[7:0];
			slow_clock_enable_out <= 1'b0;
			ratio_busy_out <= 1'b0;
		end else begin
			slow_clock_control <= next_slow;
			fast_clock_trim_control <= next_fast;
			converter_timing_setting <= next_timing;
			sample_sync_config <= next_sync;
			clock_calibration_control <= next_cal;
			outside_sync_reg <= next_osync;
			sample_rate_divider <= next_rate;
			reg_rdata_out <= next_rdata;
			irq_sync <= {irq_sync[1:0], irq_pin_in};
			fast_sync <= {fast_sync[1:0], fast_osc_in};
			irq_level <= next_irq_level;
			fast_level <= next_fast_level;
			samp_cnt <= next_samp_cnt;
			sample_start_out <= next_sample;
			cal_state <= next_cal_state;
			clk_ratio <= next_ratio;
			fast_cnt <= next_fast_cnt;
			win_cnt <= next_win_cnt;
			start_seen <= next_start_seen;
			// Trim codes pass straight to the oscillators.
			slow_clock_trim_out <= slow_clock_control[5:0];
			fast_clock_trim_out <= fast_clock_trim_control[7:0];
			slow_clock_enable_out <= slow_clock_enable;
			ratio_busy_out <= (next_cal_state == SCT_MEAS);
		end
	end

	// Checks.
	a_pin_gated: assert property (sample_start_out &&
		$past(sample_sync_source) |-> $past(irq_pin_input_enable))
		else $error("pin start while off");
	a_clk_off: assert property (!$past(slow_clock_enable) |->
		!sample_start_out) else $error("sample with clock off");
	a_cal_launch: assert property (cal_state == SCT_IDLE &&
		fast_clock_ratio_start && !start_seen |=> ratio_busy_out)
		else $error("ratio not launched");
	a_no_relaunch: assert property (cal_state == SCT_IDLE &&
		start_seen |=> cal_state == SCT_IDLE)
		else $error("relaunch without clear");
	a_trim_follow: assert property (reg_wr_in &&
		reg_addr_in == SCT_ADDR_FAST |=> ##1
		fast_clock_trim_out == $past(reg_wdata_in[7:0], 2))
		else $error("fast trim lost");
	a_slow_trim: assert property (reg_wr_in &&
		reg_addr_in == SCT_ADDR_SLOW |=> ##1
		slow_clock_trim_out == $past(reg_wdata_in[5:0], 2))
		else $error("slow trim lost");
	a_ratio_read: assert property (reg_rd_in &&
		reg_addr_in == SCT_ADDR_RATIO |=> reg_rdata_out == $past(clk_ratio))
		else $error("ratio read");
	a_int_mode: assert property (sample_start_out &&
		!$past(sample_sync_source) |-> $past(slow_tick))
		else $error("internal start off tick");
	c_int_sample: cover property (@(posedge ref_clk_in)
		sample_start_out && !sample_sync_source);
	c_pin_sample: cover property (@(posedge ref_clk_in)
		sample_start_out && sample_sync_source);
	c_ratio_done: cover property (@(posedge ref_clk_in)
		$fell(ratio_busy_out));
endmodule : sct_clock_ctrl

//--- sct_far_side.sv
// Far-side model: free-running fast oscillator and outside trigger source.
// Assumes the bench requests each trigger with a rising edge on trig_in.
`timescale 1ns/1ns
module sct_far_side (
	// Trigger request from the bench.
	input wire logic trig_in,
	// Pin and oscillator levels toward the block.
	output logic irq_pin_out,
	output logic fast_osc_out
);
	// The oscillator has no phase relation to the reference clock.
	initial begin
		fast_osc_out = 1'b0;
		forever #200 fast_osc_out = ~fast_osc_out;
	end
	// A pull-down holds the pin low while nobody triggers.
	initial irq_pin_out = 1'b0;
	// The pulse outlasts three reference cycles so the synchroniser sees it.
	always @(posedge trig_in) begin
		irq_pin_out = 1'b1;
		#350;
		irq_pin_out = 1'b0;
	end
endmodule : sct_far_side

//--- testbench.sv
// Self-checking bench for the sample clock trim and sync control.
// Assumes the far-side model; slow ticks shortened to two reference cycles.
`timescale 1ns/1ns
module testbench;
	import sct_pkg::*;
	logic ref_clk_in, nrst_in, reg_wr_in, reg_rd_in, trig, rd_d;
	logic [7:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, d, me, md;
	logic irq_pin_in, fast_osc_in, slow_clock_enable_out;
	logic sample_start_out, ratio_busy_out;
	logic [5:0] slow_clock_trim_out;
	logic [7:0] fast_clock_trim_out;
	logic [15:0] exp_q[$], tol_q[$];
	logic [7:0] ra[8] = '{SCT_ADDR_SLOW, SCT_ADDR_FAST, SCT_ADDR_TIMING,
		SCT_ADDR_SYNC, SCT_ADDR_CAL, SCT_ADDR_OSYNC, SCT_ADDR_RATE, 8'h77};
	logic [15:0] rv[8] = '{SCT_RST_SLOW, SCT_RST_FAST, SCT_RST_TIMING,
		SCT_RST_SYNC, SCT_RST_CAL, SCT_RST_OSYNC, SCT_RST_RATE, 16'h0000};
	logic [5:0] sc[3] = '{6'h00, 6'h22, 6'h3F};
	logic [7:0] fc[3] = '{8'h00, 8'h5E, 8'hFF};
	int n_fail, total_checks, n_start, s0, seed, i;
	time t0;
	sct_clock_ctrl #(.SLOW_DIV(2)) dut (.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.irq_pin_in(irq_pin_in), .fast_osc_in(fast_osc_in),
		.slow_clock_trim_out(slow_clock_trim_out),
		.fast_clock_trim_out(fast_clock_trim_out),
		.slow_clock_enable_out(slow_clock_enable_out),
		.sample_start_out(sample_start_out),
		.ratio_busy_out(ratio_busy_out));
	sct_far_side far (.trig_in(trig), .irq_pin_out(irq_pin_in),
		.fast_osc_out(fast_osc_in));
	// Reference clock, 100 ns period.
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	// Compares a settled value with its expectation.
	task chk(input logic [15:0] g, input logic [15:0] x);
		total_checks++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	// One write cycle; the strobe drops before the next can start.
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	// One read cycle; the expectation and its tolerance go on the queues.
	task rd(input logic [7:0] a, input logic [15:0] x, input logic [15:0] t);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		exp_q.push_back(x);
		tol_q.push_back(t);
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1;
	endtask : rd
	// Waits, bounded, for the busy flag to reach a level.
	task wait_busy(input logic v);
		int k;
		for (k = 0; k < 200 && ratio_busy_out !== v; k++) begin
			@(posedge ref_clk_in);
			#1;
		end
		chk({15'h0000, ratio_busy_out}, {15'h0000, v});
	endtask : wait_busy
	// Waits, bounded, for the next sample start pulse.
	task next_start;
		int k;
		@(posedge ref_clk_in);
		#1;
		for (k = 0; k < 40 && sample_start_out !== 1'b1; k++) begin
			@(posedge ref_clk_in);
			#1;
		end
	endtask : next_start
	// Counts starts over a window of reference cycles; the window opens one
	// edge late so a pulse launched under the old setting is left out.
	task count_starts(input int n, input logic [15:0] x);
		@(posedge ref_clk_in);
		#1;
		s0 = n_start;
		repeat (n) @(posedge ref_clk_in);
		#1;
		chk(16'(n_start - s0), x);
	endtask : count_starts
	task final_report;
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// Read data lands one cycle after the strobe; ratio reads allow slack.
	always @(posedge ref_clk_in) begin
		if (rd_d === 1'b1) begin
			me = exp_q.pop_front();
			md = tol_q.pop_front();
			total_checks++;
			if ((reg_rdata_out + md >= me && reg_rdata_out <= me + md)
				!== 1'b1) begin
				n_fail++;
				$display("MISMATCH t=%0t got=%h exp=%h", $time,
					reg_rdata_out, me);
			end
		end
		rd_d <= reg_rd_in;
		if (sample_start_out === 1'b1)
			n_start <= n_start + 1;
	end
	// Cuts a hang short after ten thousand cycles.
	initial begin
		#1000000;
		n_fail++;
		final_report();
	end
	initial begin
		seed = 90784;
		{nrst_in, reg_wr_in, reg_rd_in, trig} = 4'h0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 16'h0000;
		n_fail = 0;
		total_checks = 0;
		repeat (5) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		#1;
		chk({10'h000, slow_clock_trim_out}, 16'h0012);
		chk({8'h00, fast_clock_trim_out}, 16'h005E);
		for (i = 0; i < 8; i++)
			rd(ra[i], rv[i], 16'h0000);
		$display("reset values test done");
		// Trim codes at the range ends, the slow centre and the fast default, then random words.
		for (i = 0; i < 6; i++) begin
			d = 16'($random(seed));
			if (i < 3)
				d = {2'b00, sc[i], fc[i]};
			wr(SCT_ADDR_FAST, d);
			wr(SCT_ADDR_SLOW, {d[7:0], d[15:8]});
			rd(SCT_ADDR_FAST, d, 16'h0000);
			rd(SCT_ADDR_SLOW, {d[7:0], d[15:8]}, 16'h0000);
			chk({8'h00, fast_clock_trim_out}, {8'h00, d[7:0]});
			chk({10'h000, slow_clock_trim_out}, {10'h000, d[13:8]});
			chk({15'h0000, slow_clock_enable_out}, {15'h0000, d[15]});
		end
		$display("trim test done");
		// Divider 2 at two cycles a tick gives a start every 16 cycles.
		wr(SCT_ADDR_RATE, 16'h0002);
		wr(SCT_ADDR_SYNC, 16'h0000);
		wr(SCT_ADDR_SLOW, 16'h0080);
		next_start();
		t0 = $time;
		next_start();
		chk(16'(($time - t0) / 100), 16'h0010);
		count_starts(160, 16'h000A);
		wr(SCT_ADDR_SLOW, 16'h0000);
		count_starts(64, 16'h0000);
		$display("internal timing test done");
		wr(SCT_ADDR_SLOW, 16'h0080);
		wr(SCT_ADDR_OSYNC, 16'h4000);
		wr(SCT_ADDR_SYNC, 16'h0006);
		trig <= 1'b1;
		count_starts(40, 16'h0001);
		trig <= 1'b0;
		wr(SCT_ADDR_SYNC, 16'h0004);
		trig <= 1'b1;
		count_starts(40, 16'h0000);
		trig <= 1'b0;
		wr(SCT_ADDR_OSYNC, 16'h0000);
		wr(SCT_ADDR_SYNC, 16'h0000);
		$display("outside trigger test done");
		// Sixteen cycles of measurement at 400 ns per fast edge.
		wr(SCT_ADDR_CAL, 16'h0020);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rd(SCT_ADDR_RATIO, 16'h0004, 16'h0001);
		wr(SCT_ADDR_RATIO, 16'hFFFF);
		rd(SCT_ADDR_RATIO, 16'h0004, 16'h0001);
		wr(SCT_ADDR_CAL, 16'h0020);
		repeat (4) @(posedge ref_clk_in);
		#1;
		chk({15'h0000, ratio_busy_out}, 16'h0000);
		wr(SCT_ADDR_CAL, 16'h0000);
		wr(SCT_ADDR_CAL, 16'h0020);
		wait_busy(1'b1);
		wait_busy(1'b0);
		$display("ratio test done");
		repeat (3) @(posedge ref_clk_in);
		final_report();
	end
endmodule : testbench
